/* File: hdl/dtc_consts.svh */
// constants for the dual timer/counter block
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
`define DTC_CTRL_ADDR     8'h88
`define DTC_MODE_ADDR     8'h89
`define DTC_CTRL_RESET    8'h00
`define DTC_MODE_RESET    8'h00
`define DTC_MCYCLE_CLKS   6
`define DTC_CTRL_TF1      7
`define DTC_CTRL_TR1      6
`define DTC_CTRL_TF0      5
`define DTC_CTRL_TR0      4
`define DTC_CTRL_IE1      3
`define DTC_CTRL_IT1      2
`define DTC_CTRL_IE0      1
`define DTC_CTRL_IT0      0
`define DTC_MODE_GATE1    7
`define DTC_MODE_GATE0    3
`define DTC_CNT_ADDR0     8'h8A
`define DTC_CNT_ADDR1     8'h8C
// bus byte addresses: each register index above times four, one word apiece
`define DTC_CTRL_BYTE     12'h220
`define DTC_MODE_BYTE     12'h224
`define DTC_CNT_BYTE0     12'h228
`define DTC_CNT_BYTE1     12'h230
`endif

/* File: hdl/dtc_pkg.sv */
// types shared by the dual timer/counter block
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_M13   = 2'b00,
    DTC_M16   = 2'b01,
    DTC_M8AR  = 2'b10,
    DTC_SPLIT = 2'b11
  } dtc_mode_e;
  // one timer's half of the mode register
  typedef struct packed {
    logic      gate;
    logic      src_pin;
    dtc_mode_e mode;
  } dtc_tmode_s;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dtc_count_s;
endpackage : dtc_pkg

/* File: hdl/dtc_timer.sv */
// two timer/counters with four modes, irq latches, axi4-lite slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_timer (
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // pins
  input  wire logic        first_count_pin_in,
  input  wire logic        second_count_pin_in,
  input  wire logic        ext_irq_zero_pin_in,
  input  wire logic        ext_irq_one_pin_in,
  // interrupt acknowledges from the processor's vectoring logic
  input  wire logic        ack_first_ovf_in,
  input  wire logic        ack_second_ovf_in,
  input  wire logic        ack_irq_zero_in,
  input  wire logic        ack_irq_one_in,
  output logic             first_overflow_flag_out,
  output logic             second_overflow_flag_out,
  output logic             irq_zero_latch_out,
  output logic             irq_one_latch_out,
  output logic             baud_tick_out
);
  logic [7:0]          timer_control_reg;
  logic [7:0]          timer_mode_reg;
  dtc_pkg::dtc_count_s cnt0;
  dtc_pkg::dtc_count_s cnt1;
  dtc_pkg::dtc_tmode_s tm0;
  dtc_pkg::dtc_tmode_s tm1;
  logic [2:0]          mc_div;
  logic                mc_tick;
  logic [1:0]          pin_smp;
  logic [1:0]          pin_fall;
  logic [1:0]          irq_prev;
  logic                en0;
  logic                en1;
  logic                en0h;
  logic                inc0;
  logic                inc1;
  logic                inc0h;
  dtc_pkg::dtc_count_s next_cnt0;
  dtc_pkg::dtc_count_s next_cnt1;
  logic                ovf0;
  logic                ovf1;
  logic                ovf0h;
  // axi
  logic                aw_held;
  logic                w_held;
  logic [11:0]         aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                wr_go;
  logic                wr_ctrl;
  logic                wr_mode;
  logic                wr_cnt0;
  logic                wr_cnt1;

  assign tm0 = dtc_pkg::dtc_tmode_s'(timer_mode_reg[3:0]);
  assign tm1 = dtc_pkg::dtc_tmode_s'(timer_mode_reg[7:4]);

  // machine cycle strobe: one clock in six
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mc_div <= 3'h0;
    end else if (mc_div == 3'(`DTC_MCYCLE_CLKS - 1)) begin
      mc_div <= 3'h0;
    end else begin
      mc_div <= mc_div + 3'h1;
    end
  end
  assign mc_tick = (mc_div == 3'(`DTC_MCYCLE_CLKS - 1));

  // count pins sampled once per machine cycle; fall = high then low sample
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_smp <= 2'h0;
    end else if (mc_tick) begin
      pin_smp <= {second_count_pin_in, first_count_pin_in};
    end
  end
  assign pin_fall = pin_smp & ~{second_count_pin_in, first_count_pin_in};

  // gating: run bit and (no qualify or irq pin high)
  assign en0  = timer_control_reg[`DTC_CTRL_TR0] &
                (~timer_mode_reg[`DTC_MODE_GATE0] | ext_irq_zero_pin_in);
  // timer one is frozen by its own split mode, as if run were clear
  assign en1  = timer_control_reg[`DTC_CTRL_TR1] & (tm1.mode != dtc_pkg::DTC_SPLIT) &
                (~timer_mode_reg[`DTC_MODE_GATE1] | ext_irq_one_pin_in);
  // split high byte: machine cycles only, gated by second run bit alone
  assign en0h = timer_control_reg[`DTC_CTRL_TR1] & (tm0.mode == dtc_pkg::DTC_SPLIT);
  assign inc0 = mc_tick & en0 & (tm0.src_pin ? pin_fall[0] : 1'b1);
  assign inc1 = mc_tick & en1 & (tm1.src_pin ? pin_fall[1] : 1'b1);
  assign inc0h = mc_tick & en0h;

  // next count and overflow for one timer; split flag only meaningful for timer zero
  function automatic logic [16:0] step(input dtc_pkg::dtc_count_s c,
                                       input dtc_pkg::dtc_mode_e m);
    logic [5:0] lo5;
    logic [8:0] hi9;
    logic [8:0] lo9;
    logic [16:0] w;
    lo5 = 6'h0;
    hi9 = 9'h0;
    lo9 = 9'h0;
    w   = 17'h0;
    unique case (m)
      dtc_pkg::DTC_M13: begin
        // upper three low bits are left as they are and ignored
        lo5 = {1'b0, c.low[4:0]} + 6'h01;
        hi9 = {1'b0, c.high} + {8'h00, lo5[5]};
        step = {hi9[8], hi9[7:0], c.low[7:5], lo5[4:0]};
      end
      dtc_pkg::DTC_M16: begin
        w = {1'b0, c} + 17'h00001;
        step = w;
      end
      dtc_pkg::DTC_M8AR: begin
        lo9 = {1'b0, c.low} + 9'h001;
        // reload from high byte, high byte untouched
        step = {lo9[8], c.high, (lo9[8] ? c.high : lo9[7:0])};
      end
      dtc_pkg::DTC_SPLIT: begin
        lo9 = {1'b0, c.low} + 9'h001;
        step = {lo9[8], c.high, lo9[7:0]};
      end
    endcase
  endfunction : step

  logic [16:0] s0;
  logic [16:0] s1;
  logic [8:0]  h0;
  assign s0 = step(cnt0, tm0.mode);
  assign s1 = step(cnt1, tm1.mode);
  assign h0 = {1'b0, cnt0.high} + 9'h001;

  // count update: software writes to count bytes beat the increment
  always_comb begin
    next_cnt0 = cnt0;
    next_cnt1 = cnt1;
    ovf0  = 1'b0;
    ovf1  = 1'b0;
    ovf0h = 1'b0;
    if (inc0) begin
      next_cnt0 = dtc_pkg::dtc_count_s'(s0[15:0]);
      ovf0      = s0[16];
    end
    if (inc0h) begin
      next_cnt0.high = h0[7:0];
      ovf0h          = h0[8];
    end
    if (inc1) begin
      next_cnt1 = dtc_pkg::dtc_count_s'(s1[15:0]);
      ovf1      = s1[16];
    end
    if (wr_cnt0) begin
      if (w_strb[0]) next_cnt0.low = w_data[7:0];
      if (w_strb[1]) next_cnt0.high = w_data[15:8];
    end
    if (wr_cnt1) begin
      if (w_strb[0]) next_cnt1.low = w_data[7:0];
      if (w_strb[1]) next_cnt1.high = w_data[15:8];
    end
  end

  // counts only move through next_cnt; run bit writes never touch them
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt0 <= 16'h0000;
      cnt1 <= 16'h0000;
    end else begin
      cnt0 <= next_cnt0;
      cnt1 <= next_cnt1;
    end
  end

  // baud overflow pulse from timer one, still live while timer zero is split
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      baud_tick_out <= 1'b0;
    end else begin
      baud_tick_out <= ovf1;
    end
  end

  // mode register: plain software storage
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      timer_mode_reg <= `DTC_MODE_RESET;
    end else if (wr_mode && w_strb[0]) begin
      timer_mode_reg <= w_data[7:0];
    end
  end

  // irq pin history for falling edge detection
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_prev <= 2'h3;
    end else begin
      irq_prev <= {ext_irq_one_pin_in, ext_irq_zero_pin_in};
    end
  end

  // control register; hardware set wins over software or ack clear
  logic set_tf0;
  logic set_tf1;
  logic set_ie0;
  logic set_ie1;
  assign set_tf0 = ovf0;
  assign set_tf1 = ovf1 | ovf0h;
  assign set_ie0 = timer_control_reg[`DTC_CTRL_IT0] ?
                   (irq_prev[0] & ~ext_irq_zero_pin_in) : ~ext_irq_zero_pin_in;
  assign set_ie1 = timer_control_reg[`DTC_CTRL_IT1] ?
                   (irq_prev[1] & ~ext_irq_one_pin_in) : ~ext_irq_one_pin_in;
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      timer_control_reg <= `DTC_CTRL_RESET;
    end else begin
      if (wr_ctrl && w_strb[0]) begin
        timer_control_reg <= w_data[7:0];
      end
      if (ack_first_ovf_in) timer_control_reg[`DTC_CTRL_TF0] <= 1'b0;
      if (ack_second_ovf_in) timer_control_reg[`DTC_CTRL_TF1] <= 1'b0;
      if (ack_irq_zero_in) timer_control_reg[`DTC_CTRL_IE0] <= 1'b0;
      if (ack_irq_one_in) timer_control_reg[`DTC_CTRL_IE1] <= 1'b0;
      if (set_tf0) timer_control_reg[`DTC_CTRL_TF0] <= 1'b1;
      if (set_tf1) timer_control_reg[`DTC_CTRL_TF1] <= 1'b1;
      if (set_ie0) timer_control_reg[`DTC_CTRL_IE0] <= 1'b1;
      if (set_ie1) timer_control_reg[`DTC_CTRL_IE1] <= 1'b1;
    end
  end
  assign first_overflow_flag_out  = timer_control_reg[`DTC_CTRL_TF0];
  assign second_overflow_flag_out = timer_control_reg[`DTC_CTRL_TF1];
  assign irq_zero_latch_out       = timer_control_reg[`DTC_CTRL_IE0];
  assign irq_one_latch_out        = timer_control_reg[`DTC_CTRL_IE1];

  // axi write: address and data caught in either order, one write at a time
  assign s_axi_awready_out = ~aw_held & ~s_axi_bvalid_out;
  assign s_axi_wready_out  = ~w_held & ~s_axi_bvalid_out;
  assign wr_go   = aw_held & w_held;
  // only the low twelve address bits are decoded, so higher bits alias
  assign wr_ctrl = wr_go & (aw_addr == `DTC_CTRL_BYTE);
  assign wr_mode = wr_go & (aw_addr == `DTC_MODE_BYTE);
  assign wr_cnt0 = wr_go & (aw_addr == `DTC_CNT_BYTE0);
  assign wr_cnt1 = wr_go & (aw_addr == `DTC_CNT_BYTE1);
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_held          <= 1'b0;
      w_held           <= 1'b0;
      aw_addr          <= 12'h000;
      w_data           <= 32'h00000000;
      w_strb           <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= 2'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in[11:0];
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (wr_ctrl | wr_mode | wr_cnt0 | wr_cnt1) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // axi read: one cycle after address handshake; unmapped gives slverr
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h00000000;
      s_axi_rresp_out  <= 2'h0;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= 2'h0;
      unique case (s_axi_araddr_in[11:0])
        `DTC_CTRL_BYTE: s_axi_rdata_out <= {24'h000000, timer_control_reg};
        `DTC_MODE_BYTE: s_axi_rdata_out <= {24'h000000, timer_mode_reg};
        `DTC_CNT_BYTE0: s_axi_rdata_out <= {16'h0000, cnt0};
        `DTC_CNT_BYTE1: s_axi_rdata_out <= {16'h0000, cnt1};
        default: begin
          s_axi_rdata_out <= 32'h00000000;
          s_axi_rresp_out <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // checks
  mc_period_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    mc_tick |=> !mc_tick [*5] ##1 mc_tick) else $error("machine cycle not six clocks");
  gate_block_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!timer_control_reg[`DTC_CTRL_TR0] && !wr_cnt0 && tm0.mode != dtc_pkg::DTC_SPLIT)
    |=> cnt0 == $past(cnt0)) else $error("timer zero moved while stopped");
  qual_pin_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (timer_mode_reg[`DTC_MODE_GATE1] && !ext_irq_one_pin_in && !wr_cnt1)
    |=> cnt1 == $past(cnt1)) else $error("timer one moved with pin low");
  t1_split_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (tm1.mode == dtc_pkg::DTC_SPLIT && !wr_cnt1) |=> cnt1 == $past(cnt1))
    else $error("timer one counted in mode 11");
  reload_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (inc0 && tm0.mode == dtc_pkg::DTC_M8AR && cnt0.low == 8'hFF && !wr_cnt0)
    |=> cnt0.low == $past(cnt0.high) && cnt0.high == $past(cnt0.high)
        && timer_control_reg[`DTC_CTRL_TF0]) else $error("auto reload wrong");
  m13_carry_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (inc1 && tm1.mode == dtc_pkg::DTC_M13 && cnt1.low[4:0] == 5'h1F && !wr_cnt1)
    |=> cnt1.high == $past(cnt1.high) + 8'h01 && cnt1.low[4:0] == 5'h00)
    else $error("prescaler carry lost");
  m16_wrap_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (inc1 && tm1.mode == dtc_pkg::DTC_M16 && cnt1 == 16'hFFFF && !wr_cnt1)
    |=> cnt1 == 16'h0000 && timer_control_reg[`DTC_CTRL_TF1]) else $error("16-bit wrap");
  split_hi_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (inc0h && cnt0.high == 8'hFF) |=> timer_control_reg[`DTC_CTRL_TF1])
    else $error("split high byte overflow lost");
  level_irq_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!timer_control_reg[`DTC_CTRL_IT0] && !ext_irq_zero_pin_in)
    |=> timer_control_reg[`DTC_CTRL_IE0]) else $error("low level not latched");
  // flag and pulse checks; set must beat any clear landing in the same cycle
  tf0_set_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ovf0 |=> timer_control_reg[`DTC_CTRL_TF0]) else $error("overflow flag not set");
  tf_ack_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (ack_first_ovf_in && !set_tf0) |=> !timer_control_reg[`DTC_CTRL_TF0])
    else $error("ack did not clear flag");
  run_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !(wr_ctrl && w_strb[0]) |=>
    timer_control_reg[`DTC_CTRL_TR0] == $past(timer_control_reg[`DTC_CTRL_TR0]) &&
    timer_control_reg[`DTC_CTRL_TR1] == $past(timer_control_reg[`DTC_CTRL_TR1]))
    else $error("run bit changed without write");
  edge_irq_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (timer_control_reg[`DTC_CTRL_IT1] && irq_prev[1] && !ext_irq_one_pin_in)
    |=> timer_control_reg[`DTC_CTRL_IE1]) else $error("falling edge not latched");
  pin_only_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (tm0.src_pin && !pin_fall[0] && !wr_cnt0) |=> cnt0.low == $past(cnt0.low))
    else $error("counter moved without pin edge");
  reload_high_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (tm0.mode == dtc_pkg::DTC_M8AR && !wr_cnt0) |=> cnt0.high == $past(cnt0.high))
    else $error("reload byte changed");
  baud_pulse_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ovf1 |=> baud_tick_out) else $error("baud tick missing");
  split_lo_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (inc0 && tm0.mode == dtc_pkg::DTC_SPLIT && cnt0.low == 8'hFF && !wr_cnt0)
    |=> cnt0.low == 8'h00 && timer_control_reg[`DTC_CTRL_TF0])
    else $error("split low byte wrap wrong");
endmodule : dtc_timer

/* File: bench/dtc_pins_model.sv */
// pin-side model: count pulses and external interrupt pin levels
`timescale 1ns/1ps
module dtc_pins_model (
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [1:0] pulse_req_in,
  input  wire logic [1:0] irq_low_in,
  output logic [1:0]      count_pin_out,
  output logic [1:0]      irq_pin_out
);
  logic [4:0] phase [2];
  // interrupt pins idle high through their pull-up; low only on request
  assign irq_pin_out = ~irq_low_in;
  // one pulse: 8 clocks low then 8 high, longer than a machine cycle
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase <= '{default: 5'h00};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (phase[i] != 5'h00) begin
          phase[i] <= phase[i] - 5'h01;
        end else if (pulse_req_in[i]) begin
          phase[i] <= 5'h10;
        end
      end
    end
  end
  // pin levels follow the pulse phase, high while idle
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      count_pin_out[i] = !(phase[i] > 5'h08);
    end
  end
endmodule : dtc_pins_model

/* File: bench/dtc_timer_test.sv */
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module dtc_timer_test;
  logic        clk;
  logic        rst     = 1'b1;
  logic [31:0] awaddr  = 32'h00000000;
  logic [31:0] wdata   = 32'h00000000;
  logic [31:0] araddr  = 32'h00000000;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [1:0]  preq    = 2'h0;
  logic [1:0]  irq_low = 2'h0;
  logic [3:0]  ack     = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, baud;
  logic [31:0] rdata, v;
  logic [1:0]  bresp, rresp, r, b, cpin, ipin;
  logic [3:0]  flg;
  int          err_count, tests_run, baud_n, b0, k;
  logic [7:0]  md;

  dtc_timer i_dtc_timer (
    .ref_clk_in(clk), .sys_rst_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .first_count_pin_in(cpin[0]), .second_count_pin_in(cpin[1]),
    .ext_irq_zero_pin_in(ipin[0]), .ext_irq_one_pin_in(ipin[1]),
    .ack_first_ovf_in(ack[0]), .ack_second_ovf_in(ack[1]),
    .ack_irq_zero_in(ack[2]), .ack_irq_one_in(ack[3]),
    .first_overflow_flag_out(flg[0]), .second_overflow_flag_out(flg[1]),
    .irq_zero_latch_out(flg[2]), .irq_one_latch_out(flg[3]), .baud_tick_out(baud));

  dtc_pins_model i_dtc_pins_model (
    .ref_clk_in(clk), .sys_rst_in(rst), .pulse_req_in(preq), .irq_low_in(irq_low),
    .count_pin_out(cpin), .irq_pin_out(ipin));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // baud ticks are counted so a stalled timer one shows up as no growth
  always @(posedge clk) begin
    if (baud === 1'b1) baud_n <= baud_n + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // a is the register index; the bus byte address is four times it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    awaddr  <= {22'h0, a, 2'b00};
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    b = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr  <= {22'h0, a, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(v & m, e);
  endtask : rchk

  // one-clock strobe on an acknowledge or a pulse request
  task automatic strobe(input bit p, input int i);
    if (p) preq[i] <= 1'b1;
    else ack[i] <= 1'b1;
    @(posedge clk);
    preq <= 2'h0;
    ack  <= 4'h0;
    repeat (24) @(posedge clk);
  endtask : strobe

  // preload, start, and time the overflow against k machine cycles of six clocks
  task automatic ovf(input int t, input logic [7:0] mdv, input logic [15:0] c, input int n_k);
    int n;
    wr(8'h89, {24'h000000, mdv}, 4'h1);
    wr(t ? 8'h8C : 8'h8A, {16'h0000, c}, 4'h3);
    wr(8'h88, t ? 32'h40 : 32'h10, 4'h1);
    n = 0;
    while (flg[t] !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= (n_k - 1) * 6 && n <= n_k * 6 + 6), 32'h1);
    rchk(8'h88, 32'hF0, t ? 32'hC0 : 32'h30);
  endtask : ovf

  task automatic results;
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // watchdog well beyond the thousand or so cycles the sequence needs
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    results();
  end

  initial begin
    void'($urandom(1928));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h88, 32'hFFFFFFFF, 32'h0);
    rchk(8'h89, 32'hFFFFFFFF, 32'h0);
    rd(8'h84);
    chk({30'h0, r}, 32'h2);
    chk(v, 32'h0);
    wr(8'h84, 32'hFF, 4'h1);
    chk({30'h0, b}, 32'h2);
    repeat (4) begin
      md = 8'($urandom);
      wr(8'h89, {24'h000000, md}, 4'h1);
      chk({30'h0, b}, 32'h0);
      rchk(8'h89, 32'hFF, {24'h000000, md});
    end
    ovf(0, 8'h00, 16'hFF1C, 4);
    ovf(1, 8'h00, 16'hFF1C, 4);
    k = 1 + int'($urandom % 8);
    ovf(0, 8'h01, 16'(65536 - k), k);
    ovf(1, 8'h10, 16'(65536 - k), k);
    ovf(0, 8'h02, 16'hF0FC, 4);
    strobe(0, 0);
    chk({31'h0, flg[0]}, 32'h0);
    k = 0;
    while (flg[0] !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(k <= 102), 32'h1);
    rchk(8'h8A, 32'hFF00, 32'hF000);
    // gate: counting held while the qualifying pin is low
    for (int t = 0; t < 2; t++) begin
      wr(8'h88, 32'h0, 4'h1);
      wr(8'h89, t ? 32'h90 : 32'h09, 4'h1);
      wr(t ? 8'h8C : 8'h8A, 32'h0, 4'h3);
      irq_low[t] <= 1'b1;
      wr(8'h88, t ? 32'h40 : 32'h10, 4'h1);
      repeat (30) @(posedge clk);
      rchk(t ? 8'h8C : 8'h8A, 32'hFFFF, 32'h0);
      irq_low[t] <= 1'b0;
      repeat (30) @(posedge clk);
      rd(t ? 8'h8C : 8'h8A);
      chk(32'(v[15:0] != 16'h0), 32'h1);
    end
    // counter function: only pin pulses advance the count
    for (int t = 0; t < 2; t++) begin
      wr(8'h88, 32'h0, 4'h1);
      wr(8'h89, t ? 32'h50 : 32'h05, 4'h1);
      wr(t ? 8'h8C : 8'h8A, 32'hFFFE, 4'h3);
      wr(8'h88, t ? 32'h40 : 32'h10, 4'h1);
      strobe(1, t);
      rchk(t ? 8'h8C : 8'h8A, 32'hFFFF, 32'hFFFF);
      chk({31'h0, flg[t]}, 32'h0);
      strobe(1, t);
      chk({31'h0, flg[t]}, 32'h1);
    end
    // interrupt latches: edge mode, then level mode
    for (int i = 0; i < 2; i++) begin
      wr(8'h88, 32'(1 << (2 * i)), 4'h1);
      irq_low[i] <= 1'b1;
      repeat (4) @(posedge clk);
      chk({31'h0, flg[2 + i]}, 32'h1);
      wr(8'h88, 32'(1 << (2 * i)), 4'h1);
      repeat (4) @(posedge clk);
      chk({31'h0, flg[2 + i]}, 32'h0);
      wr(8'h88, 32'h0, 4'h1);
      repeat (3) @(posedge clk);
      chk({31'h0, flg[2 + i]}, 32'h1);
      irq_low[i] <= 1'b0;
      strobe(0, 2 + i);
      chk({31'h0, flg[2 + i]}, 32'h0);
    end
    // split mode, timer one reloading for baud ticks
    wr(8'h89, 32'h23, 4'h1);
    wr(8'h8A, 32'hFEFC, 4'h3);
    wr(8'h8C, 32'hFFFE, 4'h3);
    wr(8'h88, 32'h50, 4'h1);
    repeat (14) @(posedge clk);
    chk({30'h0, flg[1:0]}, 32'h2);
    repeat (30) @(posedge clk);
    chk({31'h0, flg[0]}, 32'h1);
    chk(32'(baud_n > 0), 32'h1);
    wr(8'h89, 32'h33, 4'h1);
    repeat (4) @(posedge clk);
    b0 = baud_n;
    rd(8'h8C);
    md = v[7:0];
    repeat (60) @(posedge clk);
    chk(32'(baud_n == b0), 32'h1);
    rchk(8'h8C, 32'hFF, {24'h000000, md});
    results();
  end
endmodule : dtc_timer_test
